// ### psm_pkg.sv
package psm_pkg;

   // APB register map (byte addresses)
   localparam logic [11:0] ADDR_CLOCK_DIVIDER_REG  = 12'h0000;
   localparam logic [11:0] ADDR_RESET_CONTROL_REG    = 12'h0004;
   localparam logic [11:0] ADDR_CFG     = 12'h0008;
   localparam logic [11:0] ADDR_STATUS  = 12'h000C;

   // Clock divider register fields
   localparam int RECOVER_BIT  = 15;
   localparam int RATIO_HI     = 14;
   localparam int RATIO_LO     = 12;
   localparam int SLOWDOWN_BIT = 11;
   localparam int RCDIV_HI     = 10;
   localparam int RCDIV_LO     = 8;
   localparam int FIXED1_BIT   = 6;
   localparam logic [15:0] CLOCK_DIVIDER_REG_RESET = 16'h3140;
   localparam logic [15:0] CLOCK_DIVIDER_REG_WMASK = 16'hFF00;

   // Reset control register: regulator kept in sleep
   localparam int REG_KEEP_BIT = 8;
   localparam logic [15:0] RESET_CONTROL_REG_RESET = 16'h0000;

   // Configuration register fields
   localparam int CFG_WDT_BIT = 0;
   localparam int CFG_CFM_BIT = 1;
   localparam int CFG_SRC_HI  = 4;
   localparam int CFG_SRC_LO  = 2;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [15:0] CFG_WMASK = 16'h001F;

   // Power-save operands
   localparam logic [0:0] OP_SLEEP = 1'b0;
   localparam logic [0:0] OP_IDLE  = 1'b1;

   // Regulator wake delay
   localparam int REG_WAKE_US = 190;
   localparam int CLK_MHZ     = 125;
   localparam int REG_WAKE_CYC = REG_WAKE_US * CLK_MHZ;

   localparam int RATIO_W = 3;
   localparam int DIV_W   = 8;

   typedef enum logic [3:0] {
      ST_RUN   = 4'b0001,
      ST_IDLE  = 4'b0010,
      ST_SLEEP = 4'b0100,
      ST_WAKE  = 4'b1000
   } psm_state_type;

   typedef struct packed {
      logic       req;
      logic [0:0] operand;
   } psm_save_req_type;

   typedef struct packed {
      logic       sysclk_on;
      logic       osc_on;
      logic       low_power_rc_clock_on;
      logic       cfm_active;
      logic       periph_clk_on;
      logic       regulator_on;
   } psm_clk_ctl_type;

endpackage

// ### psm_ctrl.sv
module psm_ctrl #(
   parameter int REG_WAKE_CYCLES = psm_pkg::REG_WAKE_CYC
) (
   // Clock and reset
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // APB slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [11:0]                paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   // CPU side
   input  wire psm_pkg::psm_save_req_type  save_req,
   input  wire logic                       irq_pending,
   input  wire logic                       wdt_timeout,
   output logic                            cpu_clk_en,
   output logic                            wdt_clear,
   // Clock and power controls
   output psm_pkg::psm_clk_ctl_type        clk_ctl,
   output logic      [2:0]                 clk_src_sel
);

   ////////////////////////////////////////////////////////////////////////////
   logic [15:0]            clock_divider_reg_q;
   logic [15:0]            reset_control_reg_q;
   logic [15:0]            cfg_q;
   psm_pkg::psm_state_type state_q;
   psm_pkg::psm_state_type state_d;
   logic [2:0]             src_q;
   logic [31:0]            wake_cnt_q;
   logic [psm_pkg::DIV_W-1:0] div_cnt_q;
   logic [3:0]             div_set_q;
   logic                   wdt_clear_q;
   logic [31:0]            prdata_q;

   wire       wr_acc    = psel & penable & pwrite;
   wire       rd_acc    = psel & penable & ~pwrite;
   wire       hit_div   = paddr == psm_pkg::ADDR_CLOCK_DIVIDER_REG;
   wire       hit_reset_control_reg  = paddr == psm_pkg::ADDR_RESET_CONTROL_REG;
   wire       hit_cfg   = paddr == psm_pkg::ADDR_CFG;
   wire       hit_stat  = paddr == psm_pkg::ADDR_STATUS;
   wire       hit_any   = hit_div | hit_reset_control_reg | hit_cfg | hit_stat;
   wire       wdt_en    = cfg_q[psm_pkg::CFG_WDT_BIT];
   wire       cfm_en    = cfg_q[psm_pkg::CFG_CFM_BIT];
   wire       recover   = clock_divider_reg_q[psm_pkg::RECOVER_BIT];
   wire       slow_en   = clock_divider_reg_q[psm_pkg::SLOWDOWN_BIT];
   wire [2:0] ratio     = clock_divider_reg_q[psm_pkg::RATIO_HI:psm_pkg::RATIO_LO];
   wire       in_run    = state_q == psm_pkg::ST_RUN;
   wire       in_sleep  = state_q == psm_pkg::ST_SLEEP;
   wire       in_idle   = state_q == psm_pkg::ST_IDLE;
   wire       in_wake   = state_q == psm_pkg::ST_WAKE;
   wire       wake_evt  = irq_pending | wdt_timeout;
   wire       reg_off   = ~reset_control_reg_q[psm_pkg::REG_KEEP_BIT];
   wire       enter     = in_run & save_req.req;
   wire       recover_hit = recover & irq_pending & slow_en;
   wire       div_write = wr_acc & hit_div;

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   assign prdata  = prdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Register file; interrupt clear of doze enable wins over software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_divider_reg_q <= psm_pkg::CLOCK_DIVIDER_REG_RESET;
         reset_control_reg_q   <= psm_pkg::RESET_CONTROL_REG_RESET;
         cfg_q    <= psm_pkg::CFG_RESET;
      end else begin
         if (div_write) begin
            clock_divider_reg_q <= (pwdata[15:0] & psm_pkg::CLOCK_DIVIDER_REG_WMASK)
                        | (16'h0001 << psm_pkg::FIXED1_BIT);
         end
         if (recover_hit) begin
            clock_divider_reg_q[psm_pkg::SLOWDOWN_BIT] <= 1'b0;
         end
         if (wr_acc && hit_reset_control_reg) begin
            reset_control_reg_q <= pwdata[15:0] & (16'h0001 << psm_pkg::REG_KEEP_BIT);
         end
         if (wr_acc && hit_cfg) begin
            cfg_q <= pwdata[15:0] & psm_pkg::CFG_WMASK;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (rd_acc) begin
         prdata_q <= hit_div  ? {16'h0000, clock_divider_reg_q} :
                     hit_reset_control_reg ? {16'h0000, reset_control_reg_q} :
                     hit_cfg  ? {16'h0000, cfg_q} :
                     hit_stat ? {27'h000_0000, src_q, state_q[2:1]} : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-save state machine
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         psm_pkg::ST_RUN: begin
            if (save_req.req) begin
               state_d = (save_req.operand == psm_pkg::OP_IDLE)
                         ? psm_pkg::ST_IDLE : psm_pkg::ST_SLEEP;
            end
         end
         psm_pkg::ST_IDLE: begin
            if (wake_evt) begin
               state_d = psm_pkg::ST_RUN;
            end
         end
         psm_pkg::ST_SLEEP: begin
            if (wake_evt) begin
               state_d = reg_off ? psm_pkg::ST_WAKE : psm_pkg::ST_RUN;
            end
         end
         psm_pkg::ST_WAKE: begin
            if (wake_cnt_q == 32'(REG_WAKE_CYCLES - 1)) begin
               state_d = psm_pkg::ST_RUN;
            end
         end
         default: state_d = psm_pkg::ST_RUN;
      endcase
   end

   // Interrupt on the entry cycle is not sampled until the mode is reached,
   // so it wakes on the following cycle rather than being lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q     <= psm_pkg::ST_RUN;
         wdt_clear_q <= 1'b0;
         wake_cnt_q  <= 32'h0000_0000;
      end else begin
         state_q     <= state_d;
         wdt_clear_q <= enter & wdt_en;
         wake_cnt_q  <= in_wake ? wake_cnt_q + 32'h0000_0001 : 32'h0000_0000;
      end
   end

   // Clock source captured while running, so wake reuses it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q <= 3'b000;
      end else if (in_run) begin
         src_q <= cfg_q[psm_pkg::CFG_SRC_HI:psm_pkg::CFG_SRC_LO];
      end
   end

   assign wdt_clear   = wdt_clear_q;
   assign clk_src_sel = src_q;

   ////////////////////////////////////////////////////////////////////////////
   // Clock controls
   assign clk_ctl.sysclk_on     = ~in_sleep & ~in_wake;
   assign clk_ctl.osc_on        = ~in_sleep & ~in_wake;
   assign clk_ctl.periph_clk_on = ~in_sleep & ~in_wake;
   assign clk_ctl.cfm_active    = cfm_en & ~in_sleep & ~in_wake;
   assign clk_ctl.low_power_rc_clock_on       = in_sleep ? wdt_en : (wdt_en | cfm_en);
   assign clk_ctl.regulator_on  = ~(in_sleep & reg_off);

   ////////////////////////////////////////////////////////////////////////////
   // Doze divider: enable pulse every 2^ratio cycles; slow clock stays in
   // phase with the full-rate domain because both derive from pclk
   wire [3:0] div_set = {slow_en, ratio};
   wire [psm_pkg::DIV_W-1:0] div_last = slow_en
        ? psm_pkg::DIV_W'((9'h001 << ratio) - 9'h001) : '0;
   wire       div_tick = div_cnt_q == div_last;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_q <= '0;
         div_set_q <= 4'h0;
      end else begin
         div_set_q <= div_set;
         if (div_set != div_set_q || div_tick) begin
            div_cnt_q <= '0;
         end else begin
            div_cnt_q <= div_cnt_q + 1'b1;
         end
      end
   end

   assign cpu_clk_en = in_run & ~enter & div_tick;

   ////////////////////////////////////////////////////////////////////////////
   a_sleep_clocks_off: assert property (@(posedge pclk) disable iff (!presetn)
      in_sleep |-> !clk_ctl.sysclk_on && !clk_ctl.cfm_active && !cpu_clk_en)
      else $error("clocks running in sleep");
   a_sleep_low_power_rc_clock_wdt: assert property (@(posedge pclk) disable iff (!presetn)
      in_sleep && wdt_en |-> clk_ctl.low_power_rc_clock_on)
      else $error("rc clock off in sleep");
   a_wdt_clear_entry: assert property (@(posedge pclk) disable iff (!presetn)
      enter && wdt_en |=> wdt_clear && !in_run)
      else $error("watchdog not cleared on entry");
   a_idle_periph_on: assert property (@(posedge pclk) disable iff (!presetn)
      in_idle |-> clk_ctl.sysclk_on && clk_ctl.periph_clk_on && !cpu_clk_en)
      else $error("idle clocking wrong");
   a_idle_wake_fast: assert property (@(posedge pclk) disable iff (!presetn)
      in_idle && wake_evt |=> in_run)
      else $error("idle wake late");
   a_reg_wake_delay: assert property (@(posedge pclk) disable iff (!presetn)
      in_sleep && wake_evt && reg_off |=> in_wake [*8])
      else $error("regulator wake too short");
   a_recover_clear: assert property (@(posedge pclk) disable iff (!presetn)
      recover_hit |=> !slow_en)
      else $error("doze not cleared by interrupt");
   a_full_rate_tick: assert property (@(posedge pclk) disable iff (!presetn)
      !slow_en && $stable(div_set) |-> div_tick)
      else $error("full rate missing tick");
   a_src_held_sleep: assert property (@(posedge pclk) disable iff (!presetn)
      !in_run |=> $stable(clk_src_sel))
      else $error("clock source changed while asleep");
   a_idle_low_power_rc_clock_on: assert property (@(posedge pclk) disable iff (!presetn)
      in_idle && (wdt_en || cfm_en) |-> clk_ctl.low_power_rc_clock_on)
      else $error("rc clock off in idle");
   a_sleep_periph_off: assert property (@(posedge pclk) disable iff (!presetn)
      in_sleep |-> !clk_ctl.periph_clk_on && !clk_ctl.osc_on)
      else $error("peripheral clock running in sleep");
   a_wdt_clear_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      wdt_clear |=> !wdt_clear)
      else $error("watchdog clear longer than one cycle");
   a_enter_stalls_cpu: assert property (@(posedge pclk) disable iff (!presetn)
      enter |-> !cpu_clk_en)
      else $error("cpu advanced on power-save request");
   a_reg_on_keep: assert property (@(posedge pclk) disable iff (!presetn)
      !reg_off |-> clk_ctl.regulator_on)
      else $error("regulator off with keep bit set");

endmodule

// ### psm_cpu_model.sv
module psm_cpu_model (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // Bench commands
   input  wire logic                 exec,
   input  wire logic                 op,
   input  wire logic                 irq_in,
   // Controller side
   input  wire logic                 cpu_clk_en,
   output psm_pkg::psm_save_req_type save_req,
   output logic                      irq_pending,
   output int                        retired
);
   timeunit 1ns;
   timeprecision 1ps;
   //////////////////////////////////////////////////////////////////////
   // Decode strobe lasts one cycle, the bench never holds exec longer
   assign save_req.req     = exec;
   assign save_req.operand = op;
   // Level, so a coincident interrupt survives mode entry
   assign irq_pending = irq_in;
   //////////////////////////////////////////////////////////////////////
   // Retires one instruction per enabled cycle, stalls otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         retired <= 0;
      else if (cpu_clk_en)
         retired <= retired + 1;
   end
endmodule

// ### power_save_mode_controller_test.sv
module power_save_mode_controller_test;
   timeunit 1ns;
   timeprecision 1ps;
   // Short regulator wake keeps the run brief
   localparam int WAKE = 10;
   logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic                      cpu_clk_en, wdt_clear, irq, wdt_timeout, exec, op, irq_pending, err;
   logic [11:0]               paddr;
   logic [31:0]               pwdata, prdata, rd;
   logic [2:0]                clk_src_sel, src;
   psm_pkg::psm_save_req_type save_req;
   psm_pkg::psm_clk_ctl_type  clk_ctl;
   int                        retired, failures, checks_done, seed, n;
   //////////////////////////////////////////////////////////////////////
   psm_ctrl #(.REG_WAKE_CYCLES(WAKE)) u_psm_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .save_req(save_req), .irq_pending(irq_pending),
      .wdt_timeout(wdt_timeout), .cpu_clk_en(cpu_clk_en), .wdt_clear(wdt_clear),
      .clk_ctl(clk_ctl), .clk_src_sel(clk_src_sel));
   psm_cpu_model u_psm_cpu_model (.pclk(pclk), .presetn(presetn), .exec(exec), .op(op),
      .irq_in(irq), .cpu_clk_en(cpu_clk_en), .save_req(save_req),
      .irq_pending(irq_pending), .retired(retired));
   initial begin
      pclk = 0;
      forever #4 pclk = ~pclk;
   end
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic summarize();
      if (failures == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic tmo();
      failures++;
      summarize();
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk) penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50)
         tmo();
      chk(pready, 1);
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1 rd = prdata;
   endtask
   // Counts edges until the CPU may advance again
   task automatic wait_en(output int k);
      k = 0;
      do begin
         @(posedge pclk);
         #1 k++;
      end while (cpu_clk_en !== 1'b1 && k < 300);
      if (k >= 300)
         tmo();
   endtask
   task automatic pwr(input logic o, input logic early, input logic keep);
      int r0, k;
      @(posedge pclk);
      exec <= 1'b1;
      op   <= o;
      irq  <= early;
      @(posedge pclk);
      chk(cpu_clk_en, 0);
      exec <= 1'b0;
      r0 = retired;
      #1 chk(wdt_clear, 1);
      chk(clk_ctl, o ? 6'h3F : {5'b00100, keep});
      if (!early) begin
         @(posedge pclk);
         if (o)
            wdt_timeout <= 1'b1;
         else
            irq <= 1'b1;
      end
      wait_en(k);
      chk(k, (o || keep) ? 1 : 1 + WAKE);
      chk(retired - r0, 0);
      chk(clk_src_sel, src);
      @(posedge pclk);
      irq         <= 1'b0;
      wdt_timeout <= 1'b0;
   endtask
   //////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'hf37f;
      {presetn, psel, penable, pwrite, exec, op, irq, wdt_timeout} = '0;
      paddr  = '0;
      pwdata = '0;
      failures = 0;
      checks_done = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, psm_pkg::ADDR_CLOCK_DIVIDER_REG, 0);
      chk(rd, 32'h0000_3140);
      apb(1, 12'h010, 32'hFFFF_FFFF);
      chk(err, 1);
      apb(0, 12'h010, 0);
      chk(rd, 0);
      apb(1, psm_pkg::ADDR_CLOCK_DIVIDER_REG, 32'hFFFF_FFFF);
      apb(0, psm_pkg::ADDR_CLOCK_DIVIDER_REG, 0);
      chk(rd, 32'h0000_FF40);
      // Every ratio code, period between CPU strobes
      for (int r = 0; r < 8; r++) begin
         apb(1, psm_pkg::ADDR_CLOCK_DIVIDER_REG, {16'h0, 1'b0, r[2:0], 1'b1, 11'h0});
         wait_en(n);
         wait_en(n);
         chk(n, 1 << r);
         chk(clk_ctl.periph_clk_on, 1);
      end
      apb(1, psm_pkg::ADDR_CLOCK_DIVIDER_REG, 0);
      src = 3'($random(seed));
      apb(1, psm_pkg::ADDR_CFG, {27'h0, src, 2'b11});
      pwr(psm_pkg::OP_SLEEP, 0, 0);
      pwr(psm_pkg::OP_IDLE, 0, 0);
      apb(1, psm_pkg::ADDR_RESET_CONTROL_REG, 32'h0000_0100);
      pwr(psm_pkg::OP_SLEEP, 1, 1);
      // Interrupt in doze, with and without recovery
      for (int c = 0; c < 2; c++) begin
         apb(1, psm_pkg::ADDR_CLOCK_DIVIDER_REG, {16'h0, c[0], 3'd3, 1'b1, 11'h0});
         @(posedge pclk) irq <= 1'b1;
         @(posedge pclk) irq <= 1'b0;
         apb(0, psm_pkg::ADDR_CLOCK_DIVIDER_REG, 0);
         chk(rd, {16'h0, c[0], 3'd3, ~c[0], 11'h040});
      end
      // Reset while asleep wakes the device
      @(posedge pclk) exec <= 1'b1;
      @(posedge pclk) exec <= 1'b0;
      #1 chk(clk_ctl.sysclk_on, 0);
      @(posedge pclk) presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      #1 chk(cpu_clk_en, 1);
      apb(0, psm_pkg::ADDR_STATUS, 0);
      chk(rd, 0);
      summarize();
   end
endmodule
